/* File: phcs_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "phcs_cfg.svh"
module phcs_regs #(
    parameter logic [4:0] PHY_ADDR = 5'h01,
    // wake pulse period; shorten in simulation
    parameter int NLP_CYC = `PHCS_NLP_CYC,
    parameter int NLP_CW = 25
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    // serial management pins
    input wire logic MDC_I,
    input wire logic MDIO_I,
    output logic MDIO_O,
    output logic MDIO_OE_O,
    // strap pin for crossover default
    input wire logic STRAP_AMDIX_I,
    // from basic mode control logic
    input wire logic BMC_SPEED100_I,
    // normal link enables from link monitors
    input wire logic LINK_EN10_I,
    input wire logic LINK_EN100_I,
    // status sources, same clock
    input wire logic SPEED100_I,
    input wire logic FULL_DUPLEX_I,
    input wire logic PAGE_RX_I,
    input wire logic AN_DONE_I,
    input wire logic LINK_UP_I,
    input wire logic MDIX_ACTIVE_I,
    input wire logic POL_POS_I,
    input wire logic JABBER_I,
    input wire logic ENERGY_I,
    // controls toward the datapath
    output logic [3:0] TX_DEPTH_O,
    output logic LINK_EN10_O,
    output logic LINK_EN100_O,
    output logic PWR_DOWN_O,
    output logic PLL_PWR_DOWN_O,
    output logic REFCLK_SEL_O,
    output logic ENERGY_DET_EN_O,
    output logic NLP_SEND_O,
    output logic AMDIX_EN_O,
    output logic MDIX_MANUAL_O,
    output logic JABBER_EN_O
);
    import phcs_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [1:0] strap_s;   // strap sync chain
        logic [15:0] ctl;      // control register image
        logic [15:0] sts;      // status register image
        logic page_lh;         // latched page flag
        logic [3:0] depth;
        logic en10;
        logic en100;
        logic pd;
        logic pll_pd;
        logic refclk;
        logic ed_en;
        logic nlp;
        logic amdix;
        logic mmdix;
        logic jab_en;
    } phcs_regs_st_t;

    phcs_regs_st_t q, d;

    // management bus side
    logic bus_rd;              // read of a known register, one cycle
    logic bus_wr;              // write frame done, one cycle
    logic [4:0] bus_reg;       // register address of the frame
    logic [15:0] bus_wdata;    // write data of the frame
    logic [15:0] bus_rdata;    // read data, combinational from images
    logic bus_known;           // address belongs to this block

    // sleep controller side
    logic asleep;
    logic nlp_tick;
    logic ctl_wr;
    phcs_pwr_t pwr_mode;
    phcs_pwr_t next_mode;      // mode once a pending write lands

    ////////////////////////////////////////////////////////////////////
    // management bus slave

    phcs_mdio #(
        .PHY_ADDR(PHY_ADDR)
    ) u_mdio (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .mdc_i(MDC_I),
        .mdio_i(MDIO_I),
        .mdio_o(MDIO_O),
        .mdio_oe_o(MDIO_OE_O),
        .rd_o(bus_rd),
        .wr_o(bus_wr),
        .reg_o(bus_reg),
        .wdata_o(bus_wdata),
        .rdata_i(bus_rdata),
        .known_i(bus_known)
    );

    // read mux; both images already hold zeros in reserved bits
    always_comb
    begin
        bus_known = (bus_reg == `PHCS_ADDR_CONTROL) || (bus_reg == `PHCS_ADDR_STATUS);
        if (bus_reg == `PHCS_ADDR_CONTROL)
            bus_rdata = q.ctl;
        else if (bus_reg == `PHCS_ADDR_STATUS)
            bus_rdata = q.sts;
        else
            bus_rdata = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////
    // sleep controller

    assign ctl_wr = bus_wr && (bus_reg == `PHCS_ADDR_CONTROL);
    assign pwr_mode = phcs_pwr_t'(q.ctl[`PHCS_CTL_PWR_HI:`PHCS_CTL_PWR_LO]);
    assign next_mode = ctl_wr ? phcs_pwr_t'(bus_wdata[`PHCS_CTL_PWR_HI:`PHCS_CTL_PWR_LO]) : pwr_mode;

    phcs_sleep #(
        .NLP_CYC(NLP_CYC),
        .CW(NLP_CW)
    ) u_sleep (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .mode_i(next_mode),
        .mode_wr_i(ctl_wr),
        .energy_i(ENERGY_I),
        .asleep_o(asleep),
        .nlp_o(nlp_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // next state of registers and decoded controls

    always_comb
    begin
        d = q;
        // strap passes two stages before use
        d.strap_s = {q.strap_s[0], STRAP_AMDIX_I};

        // control write: only defined bits take data
        if (ctl_wr)
            d.ctl = bus_wdata & `PHCS_CTL_WMASK;

        // page flag: a new page beats the clear on read
        if (PAGE_RX_I)
            d.page_lh = 1'b1;
        else if (bus_rd && (bus_reg == `PHCS_ADDR_STATUS))
            d.page_lh = 1'b0;

        // status image, reserved bits forced low
        d.sts = 16'h0000;
        d.sts[`PHCS_STS_SPEED] = SPEED100_I;
        d.sts[`PHCS_STS_DUPLEX] = FULL_DUPLEX_I;
        d.sts[`PHCS_STS_PAGE] = d.page_lh;
        d.sts[`PHCS_STS_ANDONE] = AN_DONE_I;
        d.sts[`PHCS_STS_LINK] = LINK_UP_I;
        d.sts[`PHCS_STS_MDIX] = MDIX_ACTIVE_I;
        d.sts[`PHCS_STS_SLEEP] = asleep;
        d.sts[`PHCS_STS_POL] = POL_POS_I;
        d.sts[`PHCS_STS_JAB] = JABBER_I;

        // transmit buffer depth in nibbles
        unique case (q.ctl[`PHCS_CTL_DEPTH_HI:`PHCS_CTL_DEPTH_LO])
            2'b00: d.depth = 4'h4;
            2'b01: d.depth = 4'h5;
            2'b10: d.depth = 4'h6;
            2'b11: d.depth = 4'h8;
        endcase

        // forced link asserts the enable for the chosen speed only
        if (q.ctl[`PHCS_CTL_FORCE])
        begin
            d.en10 = ~BMC_SPEED100_I;
            d.en100 = BMC_SPEED100_I;
        end
        else
        begin
            d.en10 = LINK_EN10_I;
            d.en100 = LINK_EN100_I;
        end

        // power domains; management logic is never switched off.
        // software is expected to isolate via basic control too,
        // this block does not check that it did
        d.pd = (pwr_mode == PHCS_PWR_GENERAL) || asleep;
        d.pll_pd = (pwr_mode == PHCS_PWR_GENERAL) && q.ctl[`PHCS_CTL_PLLDIS];
        d.refclk = d.pll_pd;
        // energy detect stays alive in both sleep modes
        d.ed_en = (pwr_mode == PHCS_PWR_ACTIVE_SLEEP)
                  || (pwr_mode == PHCS_PWR_PASSIVE_SLEEP);
        d.nlp = nlp_tick;

        // crossover: manual choice only matters with auto off
        d.amdix = q.ctl[`PHCS_CTL_AMDIX];
        d.mmdix = ~q.ctl[`PHCS_CTL_AMDIX] & q.ctl[`PHCS_CTL_MMDIX];

        // jabber detection enabled while the disable bit is clear
        d.jab_en = ~q.ctl[`PHCS_CTL_JABDIS];

        // synchronous reset; strap keeps sampling meanwhile
        if (RST_I)
        begin
            d.ctl = `PHCS_CTL_RESET;
            // strap default comes from the synchronised pin,
            // so hold reset at least three clocks
            d.ctl[`PHCS_CTL_AMDIX] = q.strap_s[1];
            d.sts = 16'h0000;
            d.page_lh = 1'b0;
            d.depth = 4'h5;
            d.en10 = 1'b0;
            d.en100 = 1'b0;
            d.pd = 1'b0;
            d.pll_pd = 1'b0;
            d.refclk = 1'b0;
            d.ed_en = 1'b0;
            d.nlp = 1'b0;
            d.amdix = 1'b0;
            d.mmdix = 1'b0;
            d.jab_en = 1'b1;
        end
    end

    // register the whole state
    always_ff @(posedge MCLK_I)
    begin
        q <= d;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from state

    assign TX_DEPTH_O = q.depth;
    assign LINK_EN10_O = q.en10;
    assign LINK_EN100_O = q.en100;
    assign PWR_DOWN_O = q.pd;
    assign PLL_PWR_DOWN_O = q.pll_pd;
    assign REFCLK_SEL_O = q.refclk;
    assign ENERGY_DET_EN_O = q.ed_en;
    assign NLP_SEND_O = q.nlp;
    assign AMDIX_EN_O = q.amdix;
    assign MDIX_MANUAL_O = q.mmdix;
    assign JABBER_EN_O = q.jab_en;
endmodule : phcs_regs
`default_nettype wire

/* File: phcs_cfg.svh */
// Functional notes
// - buffer depth codes give 4,5,6,8 nibbles; reset 5
// - forced link drives enable per selected speed
// - mode 00 normal, 01 general power-down
// - general power-down plus PLL bit stops PLL
// - active sleep sends pulse every 1.4 s
// - passive sleep keeps management and energy detect
// - bit 6 auto crossover, reset from strap
// - bit 5 picks MDI or MDI-X manually
// - bit 0 set disables jabber, resets zero
// - status bit 14 shows speed
// - status bit 13 shows full duplex
// - status bit 12 latches page received
// - status bit 11 shows negotiation done
// - status bit 10 shows link up
// - status bit 8 shows MDI-X in use
// - status bit 6 shows sleep state
// - status bit 1 shows receive polarity
// - status bit 0 shows jabber present
`ifndef PHCS_CFG_SVH
`define PHCS_CFG_SVH

// register addresses on the management bus
`define PHCS_ADDR_CONTROL 5'h10
`define PHCS_ADDR_STATUS 5'h11

// control register fields
`define PHCS_CTL_DEPTH_HI 15
`define PHCS_CTL_DEPTH_LO 14
`define PHCS_CTL_FORCE 10
`define PHCS_CTL_PWR_HI 9
`define PHCS_CTL_PWR_LO 8
`define PHCS_CTL_AMDIX 6
`define PHCS_CTL_MMDIX 5
`define PHCS_CTL_PLLDIS 4
`define PHCS_CTL_JABDIS 0
`define PHCS_CTL_WMASK 16'hC771
`define PHCS_CTL_RESET 16'h4000

// status register fields
`define PHCS_STS_SPEED 14
`define PHCS_STS_DUPLEX 13
`define PHCS_STS_PAGE 12
`define PHCS_STS_ANDONE 11
`define PHCS_STS_LINK 10
`define PHCS_STS_MDIX 8
`define PHCS_STS_SLEEP 6
`define PHCS_STS_POL 1
`define PHCS_STS_JAB 0

// serial frame figures
`define PHCS_PRE_BITS 6'd32
`define PHCS_HDR_BITS 4'd12
`define PHCS_OP_READ 2'b10
`define PHCS_OP_WRITE 2'b01

// wake pulse period in active sleep
`define PHCS_CLK_KHZ 20000
`define PHCS_NLP_MS 1400
`define PHCS_NLP_CYC (`PHCS_NLP_MS * `PHCS_CLK_KHZ)

`endif

/* File: phcs_pkg.sv */
package phcs_pkg;
    // power-down mode field encodings
    typedef enum logic [1:0]
    {
        PHCS_PWR_NORMAL = 2'b00,
        PHCS_PWR_GENERAL = 2'b01,
        PHCS_PWR_ACTIVE_SLEEP = 2'b10,
        PHCS_PWR_PASSIVE_SLEEP = 2'b11
    } phcs_pwr_t;

    // serial frame phases
    typedef enum logic [2:0]
    {
        PHCS_FR_PRE,
        PHCS_FR_START,
        PHCS_FR_HDR,
        PHCS_FR_TA,
        PHCS_FR_DATA
    } phcs_frame_t;

    // sleep controller states
    typedef enum logic [1:0]
    {
        PHCS_SL_AWAKE,
        PHCS_SL_ASLEEP,
        PHCS_SL_WOKEN
    } phcs_sleep_t;
endpackage : phcs_pkg

/* File: phcs_mdio.sv */
`timescale 1ns/1ps
`default_nettype none
`include "phcs_cfg.svh"
module phcs_mdio #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    output logic rd_o,
    output logic wr_o,
    output logic [4:0] reg_o,
    output logic [15:0] wdata_o,
    input wire logic [15:0] rdata_i,
    input wire logic known_i
);
    import phcs_pkg::*;

    typedef struct packed {
        logic [2:0] mdc_s;     // clock sync chain plus edge stage
        logic [1:0] dat_s;     // data sync chain
        phcs_frame_t ph;
        logic [5:0] cnt;
        logic [15:0] sr;       // header, write data or read data
        logic [1:0] op;
        logic mine;            // frame is for us
        logic [4:0] ra;        // register address of the frame
        logic fetch;           // look up the register on the next clock
        logic rd;
        logic wr;
        logic o;
        logic oe;
    } phcs_mdio_st_t;

    phcs_mdio_st_t q, d;
    logic rise;
    logic bit_v;

    ////////////////////////////////////////////////////////////////////
    // next state: sample on each management clock rising edge
    always_comb
    begin
        d = q;
        d.mdc_s = {q.mdc_s[1:0], mdc_i};
        d.dat_s = {q.dat_s[0], mdio_i};
        d.rd = 1'b0;
        d.wr = 1'b0;
        // only the second stages and the clock edge stage feed logic
        rise = q.mdc_s[1] & ~q.mdc_s[2];
        bit_v = q.dat_s[1];
        if (rise)
        begin
            unique case (q.ph)
                PHCS_FR_PRE:
                begin
                    // a full run of ones then a zero starts a frame
                    if (bit_v)
                        d.cnt = (q.cnt == `PHCS_PRE_BITS) ? q.cnt : q.cnt + 6'd1;
                    else if (q.cnt == `PHCS_PRE_BITS)
                        d.ph = PHCS_FR_START;
                    else
                        d.cnt = 6'd0;
                end
                PHCS_FR_START:
                begin
                    d.cnt = 6'd0;
                    d.ph = bit_v ? PHCS_FR_HDR : PHCS_FR_PRE;
                end
                PHCS_FR_HDR:
                begin
                    d.sr = {q.sr[14:0], bit_v};
                    d.cnt = q.cnt + 6'd1;
                    if (q.cnt == {2'b00, `PHCS_HDR_BITS} - 6'd1)
                    begin
                        // last address bit is still on the line
                        d.op = q.sr[10:9];
                        d.mine = (q.sr[8:4] == PHY_ADDR);
                        d.ra = {q.sr[3:0], bit_v};
                        d.fetch = 1'b1;
                        d.cnt = 6'd0;
                        d.ph = PHCS_FR_TA;
                    end
                end
                PHCS_FR_TA:
                begin
                    d.cnt = q.cnt + 6'd1;
                    if (q.mine && (q.op == `PHCS_OP_READ))
                    begin
                        d.oe = 1'b1;
                        d.o = (q.cnt == 6'd0) ? 1'b0 : q.sr[15];
                        if (q.cnt != 6'd0)
                            d.sr = {q.sr[14:0], 1'b0};
                    end
                    if (q.cnt == 6'd1)
                    begin
                        d.cnt = 6'd0;
                        d.ph = PHCS_FR_DATA;
                    end
                end
                PHCS_FR_DATA:
                begin
                    d.cnt = q.cnt + 6'd1;
                    if (q.oe)
                    begin
                        d.o = q.sr[15];
                        d.sr = {q.sr[14:0], 1'b0};
                    end
                    else
                        d.sr = {q.sr[14:0], bit_v};
                    if (q.cnt == 6'd15)
                    begin
                        // frame over; preamble is always required again
                        d.oe = 1'b0;
                        d.o = 1'b0;
                        d.wr = q.mine && (q.op == `PHCS_OP_WRITE);
                        d.cnt = 6'd0;
                        d.ph = PHCS_FR_PRE;
                    end
                end
            endcase
        end
        // address now registered: look up the register images
        if (q.fetch)
        begin
            d.fetch = 1'b0;
            d.mine = q.mine && known_i;
            if (q.mine && known_i && (q.op == `PHCS_OP_READ))
            begin
                d.rd = 1'b1;
                d.sr = rdata_i;
            end
        end
        if (rst_i)
        begin
            d.ph = PHCS_FR_PRE;
            d.ra = 5'h00;
            d.fetch = 1'b0;
            d.cnt = 6'd0;
            d.sr = 16'h0000;
            d.op = 2'b00;
            d.mine = 1'b0;
            d.rd = 1'b0;
            d.wr = 1'b0;
            d.o = 1'b0;
            d.oe = 1'b0;
        end
    end

    // register the whole state
    always_ff @(posedge clk_i)
    begin
        q <= d;
    end

    assign mdio_o = q.o;
    assign mdio_oe_o = q.oe;
    assign rd_o = q.rd;
    assign wr_o = q.wr;
    assign reg_o = q.ra;
    assign wdata_o = q.sr;
endmodule : phcs_mdio
`default_nettype wire

/* File: phcs_sleep.sv */
`timescale 1ns/1ps
`default_nettype none
`include "phcs_cfg.svh"
module phcs_sleep #(
    parameter int NLP_CYC = `PHCS_NLP_CYC,
    parameter int CW = 25
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire phcs_pkg::phcs_pwr_t mode_i,
    input wire logic mode_wr_i,
    input wire logic energy_i,
    output logic asleep_o,
    output logic nlp_o
);
    import phcs_pkg::*;

    typedef struct packed {
        phcs_sleep_t st;
        logic [CW-1:0] tmr;
        logic nlp;
    } phcs_sleep_st_t;

    phcs_sleep_st_t q, d;
    logic sleep_mode;

    ////////////////////////////////////////////////////////////////////
    // sleep entry on a mode write, wake on energy from a partner
    always_comb
    begin
        d = q;
        d.nlp = 1'b0;
        sleep_mode = (mode_i == PHCS_PWR_ACTIVE_SLEEP) || (mode_i == PHCS_PWR_PASSIVE_SLEEP);
        unique case (q.st)
            PHCS_SL_AWAKE:
                if (mode_wr_i && sleep_mode)
                    d.st = PHCS_SL_ASLEEP;
            PHCS_SL_ASLEEP:
            begin
                // partner seen: power returns by itself
                if (!sleep_mode)
                    d.st = PHCS_SL_AWAKE;
                else if (energy_i)
                    d.st = PHCS_SL_WOKEN;
                // active sleep probes the wire now and then
                if ((mode_i == PHCS_PWR_ACTIVE_SLEEP) && (d.st == PHCS_SL_ASLEEP))
                begin
                    if (q.tmr == CW'(NLP_CYC - 1))
                    begin
                        d.tmr = '0;
                        d.nlp = 1'b1;
                    end
                    else
                        d.tmr = q.tmr + CW'(1);
                end
            end
            PHCS_SL_WOKEN:
                // stays up until software picks a mode again
                if (mode_wr_i)
                    d.st = sleep_mode ? PHCS_SL_ASLEEP : PHCS_SL_AWAKE;
            default:
                d.st = PHCS_SL_AWAKE;
        endcase
        if (q.st != PHCS_SL_ASLEEP)
            d.tmr = '0;
        if (rst_i)
        begin
            d.st = PHCS_SL_AWAKE;
            d.tmr = '0;
            d.nlp = 1'b0;
        end
    end

    // register the whole state
    always_ff @(posedge clk_i)
    begin
        q <= d;
    end

    assign asleep_o = (q.st == PHCS_SL_ASLEEP);
    assign nlp_o = q.nlp;
endmodule : phcs_sleep
`default_nettype wire

/* File: phcs_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module phcs_regs_monitor #(
    parameter int NLP_CYC = 50
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic BMC_SPEED100_I,
    input wire logic LINK_EN10_I,
    input wire logic ENERGY_I,
    input wire logic MDIO_O,
    input wire logic MDIO_OE_O,
    input wire logic [3:0] TX_DEPTH_O,
    input wire logic LINK_EN10_O,
    input wire logic LINK_EN100_O,
    input wire logic PWR_DOWN_O,
    input wire logic PLL_PWR_DOWN_O,
    input wire logic REFCLK_SEL_O,
    input wire logic ENERGY_DET_EN_O,
    input wire logic NLP_SEND_O,
    input wire logic AMDIX_EN_O,
    input wire logic MDIX_MANUAL_O,
    input wire logic JABBER_EN_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);
    // cycles since the last wake pulse
    logic [31:0] gap_q;
    // a pulse was seen in this unbroken sleep; a wake restarts the count
    logic seen_q;
    // only a lower bound is checked, since a switch to passive sleep holds the timer
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I || NLP_SEND_O)
            gap_q <= 32'h0000_0000;
        else
            gap_q <= gap_q + 32'h0000_0001;
        seen_q <= !RST_I && PWR_DOWN_O && ENERGY_DET_EN_O && (seen_q || NLP_SEND_O);
    end
    AST_RST_VAL: assert property (disable iff (1'b0)
        RST_I |=> TX_DEPTH_O == 4'h5 && JABBER_EN_O && !PWR_DOWN_O && !MDIO_OE_O)
        else $error("reset values wrong");
    AST_FORCE: assert property (
        !$past(RST_I) && LINK_EN10_O != $past(LINK_EN10_I)
        |-> LINK_EN100_O == !LINK_EN10_O && LINK_EN100_O == $past(BMC_SPEED100_I))
        else $error("forced link enables wrong");
    AST_GEN_PD: assert property (
        PLL_PWR_DOWN_O |-> PWR_DOWN_O && !ENERGY_DET_EN_O)
        else $error("pll off outside general power-down");
    AST_PLL: assert property (
        PLL_PWR_DOWN_O == REFCLK_SEL_O)
        else $error("reference clock select not tied to pll off");
    AST_NLP_SLEEP: assert property (
        NLP_SEND_O |-> PWR_DOWN_O && ENERGY_DET_EN_O ##1 !NLP_SEND_O)
        else $error("wake pulse outside sleep or too long");
    AST_NLP_GAP: assert property (
        NLP_SEND_O && seen_q |-> gap_q >= 32'(NLP_CYC - 2))
        else $error("wake pulses too close");
    AST_WAKE: assert property (
        ENERGY_DET_EN_O && ENERGY_I |-> ##[0:5] !PWR_DOWN_O)
        else $error("no wake on partner energy");
    AST_XOVER: assert property (
        MDIX_MANUAL_O |-> !AMDIX_EN_O)
        else $error("manual pairs with auto crossover on");
    AST_TA_ZERO: assert property (
        $rose(MDIO_OE_O) |-> !MDIO_O ##1 MDIO_OE_O [*4])
        else $error("turnaround not driven low");
endmodule : phcs_regs_monitor
bind phcs_regs phcs_regs_monitor #(.NLP_CYC(NLP_CYC)) i_phcs_regs_monitor (
    .MCLK_I(MCLK_I), .RST_I(RST_I), .BMC_SPEED100_I(BMC_SPEED100_I),
    .LINK_EN10_I(LINK_EN10_I), .ENERGY_I(ENERGY_I), .MDIO_O(MDIO_O), .MDIO_OE_O(MDIO_OE_O),
    .TX_DEPTH_O(TX_DEPTH_O), .LINK_EN10_O(LINK_EN10_O), .LINK_EN100_O(LINK_EN100_O),
    .PWR_DOWN_O(PWR_DOWN_O), .PLL_PWR_DOWN_O(PLL_PWR_DOWN_O), .REFCLK_SEL_O(REFCLK_SEL_O),
    .ENERGY_DET_EN_O(ENERGY_DET_EN_O), .NLP_SEND_O(NLP_SEND_O), .AMDIX_EN_O(AMDIX_EN_O),
    .MDIX_MANUAL_O(MDIX_MANUAL_O), .JABBER_EN_O(JABBER_EN_O));
`default_nettype wire

/* File: phcs_sm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module phcs_sm_model (
    input wire logic clk_i,
    input wire logic mdio_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    // management clock stands low between frames
    initial
    begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end
    // one whole frame, full preamble every time, ten clock cycles per bit
    task automatic frame(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hFFFF_FFFF, 2'b01, op, phy, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 0; i < 64; i++)
        begin
            mdc_o = 1'b0;
            // a reader lets go of the line from the turnaround on
            mdio_oe_o = (op == 2'b01) || (i < 46);
            mdio_o = bits[63 - i];
            repeat (5) @(posedge clk_i);
            #1;
            // read data is taken at the same edge that raises the clock
            if (i >= 48)
                rd = {rd[14:0], mdio_i};
            mdc_o = 1'b1;
            repeat (5) @(posedge clk_i);
            #1;
        end
        mdc_o = 1'b0;
        mdio_oe_o = 1'b0;
        // one edge between frames
        @(posedge clk_i) #1;
    endtask : frame
endmodule : phcs_sm_model
`default_nettype wire

/* File: phcs_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module phcs_regs_tb;
    localparam int NLP = 50;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic strap = 1'b1;
    logic bmc = 1'b0, l10 = 1'b0, l100 = 1'b0, energy = 1'b0, page = 1'b0;
    // speed, duplex, negotiation done, link, crossover, polarity, jabber
    logic [6:0] sts = 7'h00;
    logic mdc, m_o, m_oe, d_o, d_oe, line;
    logic [15:0] outs, rv, w;
    logic [3:0] depth;
    logic e10, e100, pd, pllpd, refsel, edet, nlp, amdix, mman, jaben;
    int error_cnt = 0;
    int n_tests = 0;
    int seed, cnt;
    always #25 mclk = !mclk;
    // the data line has a pull-up, so a released line reads high
    assign line = d_oe ? d_o : (m_oe ? m_o : 1'b1);
    assign outs = {3'h0, depth, e10, e100, pd, pllpd, refsel, edet, amdix, mman, jaben};
    phcs_regs #(.NLP_CYC(NLP), .NLP_CW(8)) i_phcs_regs (
        .MCLK_I(mclk), .RST_I(rst), .MDC_I(mdc), .MDIO_I(line), .MDIO_O(d_o),
        .MDIO_OE_O(d_oe), .STRAP_AMDIX_I(strap), .BMC_SPEED100_I(bmc), .LINK_EN10_I(l10),
        .LINK_EN100_I(l100), .SPEED100_I(sts[6]), .FULL_DUPLEX_I(sts[5]), .PAGE_RX_I(page),
        .AN_DONE_I(sts[4]), .LINK_UP_I(sts[3]), .MDIX_ACTIVE_I(sts[2]), .POL_POS_I(sts[1]),
        .JABBER_I(sts[0]), .ENERGY_I(energy), .TX_DEPTH_O(depth), .LINK_EN10_O(e10),
        .LINK_EN100_O(e100), .PWR_DOWN_O(pd), .PLL_PWR_DOWN_O(pllpd), .REFCLK_SEL_O(refsel),
        .ENERGY_DET_EN_O(edet), .NLP_SEND_O(nlp), .AMDIX_EN_O(amdix), .MDIX_MANUAL_O(mman),
        .JABBER_EN_O(jaben));
    phcs_sm_model i_phcs_sm_model (.clk_i(mclk), .mdio_i(line), .mdc_o(mdc), .mdio_o(m_o),
        .mdio_oe_o(m_oe));
    ////////////////////////////////////////
    // expected datapath controls for a control value; assumes no partner energy
    function automatic logic [15:0] ctl_outs(input logic [15:0] c);
        logic [3:0] dep;
        logic [1:0] md;
        md = c[9:8];
        dep = (c[15:14] == 2'b11) ? 4'h8 : 4'h4 + {2'b00, c[15:14]};
        return {3'h0, dep, c[10] ? !bmc : l10, c[10] ? bmc : l100, md != 2'b00,
                {2{md == 2'b01 && c[4]}}, md[1], c[6], !c[6] && c[5], !c[0]};
    endfunction : ctl_outs
    // expected status word from the driven sources
    function automatic logic [15:0] sts_exp(input logic pg, input logic sl);
        return {1'b0, sts[6:5], pg, sts[4:3], 1'b0, sts[2], 1'b0, sl, 4'h0, sts[1:0]};
    endfunction : sts_exp
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic xfer(input logic [4:0] phy, input logic rd, input logic [4:0] ra,
                        input logic [15:0] wd);
        i_phcs_sm_model.frame(phy, rd ? 2'b10 : 2'b01, ra, wd, rv);
    endtask : xfer
    // strap settles before reset so the synchroniser holds it in time
    task automatic do_reset(input logic s);
        strap = s;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
    endtask : do_reset
    task automatic tally_and_finish();
        if (error_cnt == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////
    initial
    begin
        seed = 20073;
        do_reset(1'b1);
        xfer(5'h01, 1'b1, 5'h10, 16'h0000);
        check(rv, 16'h4040);
        check(outs, ctl_outs(16'h4040));
        // every depth code and mode, random other bits, random sources
        for (int i = 0; i < 8; i++)
        begin
            w = 16'($random(seed));
            w[15:14] = i[2:1];
            w[10] = i[2] ^ i[0];
            w[9:8] = i[1:0];
            w[4] = i[2];
            xfer(5'h01, 1'b0, 5'h10, w);
            xfer(5'h01, 1'b1, 5'h10, 16'h0000);
            check(rv, w & 16'hC771);
            {bmc, l10, l100, sts} = 10'($random(seed));
            repeat (3) @(posedge mclk);
            #1 check(outs, ctl_outs(w));
            xfer(5'h01, 1'b1, 5'h11, 16'h0000);
            check(rv, sts_exp(1'b0, w[9]));
        end
        // page flag holds until read, then clears
        page = 1'b1;
        @(posedge mclk) #1 page = 1'b0;
        xfer(5'h01, 1'b1, 5'h11, 16'h0000);
        check(rv, sts_exp(1'b1, 1'b1));
        xfer(5'h01, 1'b1, 5'h11, 16'h0000);
        check(rv, sts_exp(1'b0, 1'b1));
        // active sleep: count wake pulses, then wake on partner energy
        xfer(5'h01, 1'b0, 5'h10, 16'h0200);
        cnt = 0;
        repeat (4 * NLP)
        begin
            @(posedge mclk) #1;
            cnt += int'(nlp);
        end
        check({15'h0000, cnt >= 3 && cnt <= 5}, 16'h0001);
        energy = 1'b1;
        repeat (6) @(posedge mclk);
        #1 check({15'h0000, pd}, 16'h0000);
        energy = 1'b0;
        xfer(5'h01, 1'b1, 5'h11, 16'h0000);
        check(rv, sts_exp(1'b0, 1'b0));
        // foreign address, unmapped and read-only registers are left alone
        xfer(5'h02, 1'b1, 5'h10, 16'h0000);
        check(rv, 16'hFFFF);
        xfer(5'h02, 1'b0, 5'h10, 16'hFFFF);
        xfer(5'h01, 1'b0, 5'h12, 16'hFFFF);
        xfer(5'h01, 1'b0, 5'h11, 16'hFFFF);
        xfer(5'h01, 1'b1, 5'h12, 16'h0000);
        check(rv, 16'hFFFF);
        xfer(5'h01, 1'b1, 5'h10, 16'h0000);
        check(rv, 16'h0200);
        // second reset with the strap low
        do_reset(1'b0);
        xfer(5'h01, 1'b1, 5'h10, 16'h0000);
        check(rv, 16'h4000);
        check(outs, ctl_outs(16'h4000));
        tally_and_finish();
    end
    // hang guard
    initial
    begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        tally_and_finish();
    end
endmodule : phcs_regs_tb
`default_nettype wire
